// ==== rtl/istmr_cfg.svh ====
// Offsets, field positions, response codes and timing counts of the interval timer.
`ifndef ISTMR_CFG_SVH
`define ISTMR_CFG_SVH
`define ISTMR_ADDR_W 8
`define ISTMR_OFS_SETTING 8'h00
`define ISTMR_OFS_COUNT 8'h04
`define ISTMR_OFS_STATUS 8'h08
`define ISTMR_OFS_MASK 8'h0C
`define ISTMR_SEL_LSB 6
`define ISTMR_SEL_MSB 15
`define ISTMR_SEL_W 10
`define ISTMR_CODE_W 3
`define ISTMR_CODE_CLEAR 3'h2
`define ISTMR_CNT_W 24
`define ISTMR_CNT_MAX 24'hFFFFFF
`define ISTMR_DIV_W 15
`define ISTMR_TAP_LOW_FREQ_BIT 13
`define ISTMR_XTAL_HZ 32768
`define ISTMR_PWRUP_MS 500
`define ISTMR_PWRUP_TICKS (`ISTMR_XTAL_HZ * `ISTMR_PWRUP_MS / 1000)
`define ISTMR_PWR_W 16
`define ISTMR_EVT_W 2
`define ISTMR_EVT_TICK 0
`define ISTMR_EVT_SAT 1
`define ISTMR_RESP_OKAY 2'h0
`define ISTMR_RESP_DECERR 2'h3
`endif

// ==== rtl/istmr_pkg.sv ====
// Types shared by the interval timer design.
`include "istmr_cfg.svh"
package istmr_pkg;
	typedef enum logic [3:0] {
		ST_POWERUP = 4'h1,
		ST_UNSET   = 4'h2,
		ST_GATED   = 4'h4,
		ST_ACTIVE  = 4'h8
	} istmr_state_e;
	typedef logic [`ISTMR_SEL_W-1:0] istmr_sel_t;
	typedef logic [`ISTMR_CNT_W-1:0] istmr_cnt_t;
endpackage : istmr_pkg

// ==== rtl/istmr_top.sv ====
// Interval output generator and saturating seconds counter with an AXI4-Lite slave.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ns
`include "istmr_cfg.svh"
module istmr_top #(
	parameter int PWRUP_TICKS = `ISTMR_PWRUP_TICKS,
	// A narrower divider shortens the second for simulation; at least eleven bits keep all taps.
	parameter int DIV_W       = `ISTMR_DIV_W
) (
	// Clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// AXI4-Lite write address and data
	input  wire logic [`ISTMR_ADDR_W-1:0] awaddr,
	input  wire logic                     awvalid,
	output wire logic                     awready,
	input  wire logic [31:0]              wdata,
	input  wire logic [3:0]               wstrb,
	input  wire logic                     wvalid,
	output wire logic                     wready,
	// AXI4-Lite write response
	output logic      [1:0]               bresp,
	output logic                          bvalid,
	input  wire logic                     bready,
	// AXI4-Lite read
	input  wire logic [`ISTMR_ADDR_W-1:0] araddr,
	input  wire logic                     arvalid,
	output wire logic                     arready,
	output logic      [31:0]              rdata,
	output logic      [1:0]               rresp,
	output logic                          rvalid,
	input  wire logic                     rready,
	// Device pins
	input  wire logic                     xtal_clk,
	input  wire logic                     output_gate_pin,
	output logic                          interval_out,
	// Interrupt
	output wire logic                     irq
);

	localparam logic [`ISTMR_PWR_W-1:0] PWR_LIM = `ISTMR_PWR_W'(PWRUP_TICKS);

	// ************************************************************
	// Address decode
	// ************************************************************

	function automatic logic [3:0] decode_reg(input logic [`ISTMR_ADDR_W-1:0] addr);
		logic [`ISTMR_ADDR_W-1:0] word;
		word = {addr[`ISTMR_ADDR_W-1:2], 2'h0};
		decode_reg[0] = (word == `ISTMR_OFS_SETTING);
		decode_reg[1] = (word == `ISTMR_OFS_COUNT);
		decode_reg[2] = (word == `ISTMR_OFS_STATUS);
		decode_reg[3] = (word == `ISTMR_OFS_MASK);
	endfunction : decode_reg

	// ************************************************************
	// Write channel
	// ************************************************************

	logic                     aw_held;
	logic                     w_held;
	logic [`ISTMR_ADDR_W-1:0] aw_addr_q;
	logic [31:0]              w_data_q;
	logic [3:0]               w_strb_q;
	wire                      aw_take;
	wire                      w_take;
	wire                      wr_fire;
	wire  [3:0]               wr_hit;

	assign awready = !aw_held;
	assign wready  = !w_held;
	assign aw_take = awvalid & awready;
	assign w_take  = wvalid & wready;
	// The response slot must be free, so a held write waits out a stalled bready.
	assign wr_fire = aw_held & w_held & !bvalid;
	assign wr_hit  = decode_reg(aw_addr_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'b0;
			aw_addr_q <= '0;
		end else if (aw_take) begin
			aw_held   <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (wr_fire) begin
			aw_held   <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held   <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (w_take) begin
			w_held   <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (wr_fire) begin
			w_held   <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `ISTMR_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp  <= (|wr_hit) ? `ISTMR_RESP_OKAY : `ISTMR_RESP_DECERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ************************************************************
	// Register write decode
	// ************************************************************

	wire                        set_write;
	wire                        clear_cmd;
	wire                        mask_write;
	wire [`ISTMR_EVT_W-1:0]     stat_clr;
	wire [`ISTMR_CODE_W-1:0]    wr_code;
	wire istmr_pkg::istmr_sel_t wr_sel;

	// The setting only takes effect as a whole two-byte unit.
	assign set_write  = wr_fire & wr_hit[0] & (&w_strb_q[1:0]);
	assign wr_sel     = w_data_q[`ISTMR_SEL_MSB:`ISTMR_SEL_LSB];
	assign wr_code    = w_data_q[`ISTMR_CODE_W-1:0];
	assign clear_cmd  = set_write & (wr_code == `ISTMR_CODE_CLEAR);
	assign mask_write = wr_fire & wr_hit[3] & w_strb_q[0];
	assign stat_clr   = (wr_fire & wr_hit[2] & w_strb_q[0]) ?
		w_data_q[`ISTMR_EVT_W-1:0] : '0;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************

	logic xtal_s1;
	logic xtal_s2;
	logic xtal_s3;
	logic gate_s1;
	logic gate_s2;
	wire  xtal_rise;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xtal_s1 <= 1'b0;
			xtal_s2 <= 1'b0;
			xtal_s3 <= 1'b0;
			gate_s1 <= 1'b0;
			gate_s2 <= 1'b0;
		end else begin
			xtal_s1 <= xtal_clk;
			xtal_s2 <= xtal_s1;
			xtal_s3 <= xtal_s2;
			gate_s1 <= output_gate_pin;
			gate_s2 <= gate_s1;
		end
	end

	assign xtal_rise = xtal_s2 & ~xtal_s3;

	// ************************************************************
	// Divider chain and taps
	// ************************************************************

	logic [DIV_W-1:0]           div;
	logic                       written;
	istmr_pkg::istmr_sel_t      sel;
	wire istmr_pkg::istmr_sel_t tap;
	wire                        sec_tick;
	wire                        wave;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div <= '0;
		end else if (set_write) begin
			div <= '0;
		end else if (xtal_rise) begin
			div <= div + DIV_W'(1);
		end
	end

	assign sec_tick = xtal_rise & (&div) & !set_write;

	// Select bit 0 is the slowest tap, select bit nine the fastest.
	for (genvar i = 0; i < `ISTMR_SEL_W; i++) begin : g_tap
		assign tap[i] = div[`ISTMR_TAP_LOW_FREQ_BIT + DIV_W - `ISTMR_DIV_W - i];
	end

	assign wave = (|sel) & (&(tap | ~sel));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel     <= '0;
			written <= 1'b0;
		end else if (set_write) begin
			sel     <= wr_sel;
			written <= 1'b1;
		end
	end

	// ************************************************************
	// Power-up hold
	// ************************************************************

	logic [`ISTMR_PWR_W-1:0] pwr_cnt;
	wire                     pwr_done;

	// Counted on crystal edges so the hold tracks the oscillator, not the bus clock.
	assign pwr_done = (pwr_cnt == PWR_LIM);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_cnt <= '0;
		end else if (xtal_rise && !pwr_done) begin
			pwr_cnt <= pwr_cnt + `ISTMR_PWR_W'(1);
		end
	end

	// ************************************************************
	// Output state
	// ************************************************************

	istmr_pkg::istmr_state_e state;
	istmr_pkg::istmr_state_e next_state;
	logic                    next_interval_out;

	always_comb begin
		if (!pwr_done) begin
			next_state = istmr_pkg::ST_POWERUP;
		end else if (!gate_s2) begin
			next_state = istmr_pkg::ST_GATED;
		end else if (!written) begin
			next_state = istmr_pkg::ST_UNSET;
		end else begin
			next_state = istmr_pkg::ST_ACTIVE;
		end
	end

	always_comb begin
		next_interval_out = 1'b0;
		unique case (state)
			istmr_pkg::ST_POWERUP: next_interval_out = 1'b0;
			istmr_pkg::ST_UNSET:   next_interval_out = 1'b0;
			istmr_pkg::ST_GATED:   next_interval_out = 1'b1;
			istmr_pkg::ST_ACTIVE:  next_interval_out = wave;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state        <= istmr_pkg::ST_POWERUP;
			interval_out <= 1'b0;
		end else begin
			state        <= next_state;
			interval_out <= next_interval_out;
		end
	end

	// ************************************************************
	// Seconds counter
	// ************************************************************

	istmr_pkg::istmr_cnt_t count;
	wire                   cnt_full;
	wire                   sat_event;

	assign cnt_full  = (count == `ISTMR_CNT_MAX);
	assign sat_event = sec_tick & !clear_cmd & (count == `ISTMR_CNT_MAX - 24'h1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
		end else if (clear_cmd) begin
			count <= '0;
		end else if (sec_tick && !cnt_full) begin
			count <= count + 24'h1;
		end
	end

	// ************************************************************
	// Events and interrupt
	// ************************************************************

	logic [`ISTMR_EVT_W-1:0] status;
	logic [`ISTMR_EVT_W-1:0] mask;
	wire  [`ISTMR_EVT_W-1:0] events;

	assign events[`ISTMR_EVT_TICK] = sec_tick;
	assign events[`ISTMR_EVT_SAT]  = sat_event;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= '0;
			mask   <= '0;
		end else begin
			// A new event beats a clear in the same cycle.
			status <= (status & ~stat_clr) | events;
			if (mask_write) begin
				mask <= w_data_q[`ISTMR_EVT_W-1:0];
			end
		end
	end

	assign irq = |(status & mask);

	// ************************************************************
	// Read channel
	// ************************************************************

	wire [3:0]  rd_hit;
	wire [31:0] rd_word;

	assign arready = !rvalid;
	assign rd_hit  = decode_reg(araddr);
	// The clear code is a command, not storage, so it reads back as zero.
	assign rd_word = rd_hit[0] ? {16'h0, sel, 6'h0} :
		rd_hit[1] ? {8'h0, count} :
		rd_hit[2] ? {30'h0, status} :
		rd_hit[3] ? {30'h0, mask} : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= `ISTMR_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_word;
			rresp  <= (|rd_hit) ? `ISTMR_RESP_OKAY : `ISTMR_RESP_DECERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	wire is_active = (state == istmr_pkg::ST_ACTIVE);
	wire is_gated  = (state == istmr_pkg::ST_GATED);
	wire act_zero  = is_active & (sel == '0);
	wire act_full  = is_active & cnt_full;
	wire pwr_wait  = !pwr_done;
	wire unset_hi  = pwr_done & gate_s2 & !written;
	wire gate_wr   = is_gated & set_write;

	property p_and_taps;
		$past(is_active) |-> interval_out == $past(wave);
	endproperty
	a_and_taps: assert property (p_and_taps) else $error("interval output not AND of taps");

	property p_zero_low;
		$past(act_zero) |-> !interval_out;
	endproperty
	a_zero_low: assert property (p_zero_low) else $error("output high with no taps");

	property p_gate_high;
		$past(is_gated) |-> interval_out;
	endproperty
	a_gate_high: assert property (p_gate_high) else $error("gated output not high");

	property p_gated_write;
		gate_wr ##1 is_gated |=> interval_out && written;
	endproperty
	a_gated_write: assert property (p_gated_write) else $error("gated write moved output");

	property p_write_resets;
		set_write |=> (div == '0) ##0 !sec_tick [*8];
	endproperty
	a_write_resets: assert property (p_write_resets) else $error("divider not restarted");

	property p_pwr_hold;
		$past(pwr_wait, 2) |-> !interval_out;
	endproperty
	a_pwr_hold: assert property (p_pwr_hold) else $error("output high during power-up");

	property p_unset_low;
		$past(unset_hi, 2) |-> !interval_out;
	endproperty
	a_unset_low: assert property (p_unset_low) else $error("unwritten output not low");

	property p_count_inc;
		sec_tick && !cnt_full && !clear_cmd |=> count == $past(count) + 24'h1;
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("counter missed a second");

	property p_count_sat;
		cnt_full && !clear_cmd |=> cnt_full;
	endproperty
	a_count_sat: assert property (p_count_sat) else $error("counter left saturation");

	property p_sat_wave;
		$past(act_full) |-> interval_out == $past(wave);
	endproperty
	a_sat_wave: assert property (p_sat_wave) else $error("saturation changed output");

	property p_clear;
		clear_cmd |=> count == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear code did not clear");

	property p_code_other;
		set_write && !clear_cmd && !sec_tick |=> count == $past(count);
	endproperty
	a_code_other: assert property (p_code_other) else $error("other code touched counter");

	property p_sel_kept;
		clear_cmd |=> sel == $past(wr_sel);
	endproperty
	a_sel_kept: assert property (p_sel_kept) else $error("select bits lost on clear");

	property p_tick_wrap;
		sec_tick |=> div == '0;
	endproperty
	a_tick_wrap: assert property (p_tick_wrap) else $error("tick without divider wrap");

	c_active_wave: cover property (is_active && interval_out ##1 !interval_out);
	c_gate_to_active: cover property (is_gated ##1 is_active);
	c_saturate: cover property (sat_event);
	c_clear_full: cover property (cnt_full ##1 clear_cmd);

endmodule : istmr_top

// ==== verif/istmr_host_model.sv ====
// AXI4-Lite host model that reaches the interval timer registers.
`timescale 1ns/1ns
module istmr_host_model (
	// Clock
	input  wire logic        aclk,
	// Write address, data and response
	output logic      [7:0]  awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic      [31:0] wdata,
	output logic      [3:0]  wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic        bvalid,
	output logic             bready,
	// Read address and data
	output logic      [7:0]  araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic        rvalid,
	output logic             rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// A released address or data word shows its inverse, so the slave cannot lean on stale values.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while (!(bvalid && bready));
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (!(rvalid && rready));
		rready <= 1'b0;
	endtask : rd
endmodule : istmr_host_model

// ==== verif/test_interval_signal_and_seconds_timer.sv ====
// Self-checking bench of the interval output and seconds counter block.
`timescale 1ns/1ns
module test_interval_signal_and_seconds_timer;
	localparam int PW = 8;
	// A short divider brings the second tick within reach of the run.
	localparam int DW = 11;
	logic        aclk, aresetn, xtal_clk, output_gate_pin;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, seed;
	logic [3:0]  wstrb, sel;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, interval_out, irq;
	logic [1:0]  b_q[$];
	logic [33:0] r_q[$];
	int          bad_count, n_tests, cyc, h, i;

	// ********************************
	// Clocks, design and host
	// ********************************
	initial aclk = 1'b0;
	always #10 aclk = ~aclk;
	// The crystal runs free, out of phase with the bus clock.
	initial begin
		xtal_clk = 1'b0;
		#7;
		forever #80 xtal_clk = ~xtal_clk;
	end

	istmr_top #(.PWRUP_TICKS(PW), .DIV_W(DW)) u_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .xtal_clk(xtal_clk),
		.output_gate_pin(output_gate_pin), .interval_out(interval_out), .irq(irq));

	istmr_host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rvalid(rvalid), .rready(rready));

	// ********************************
	// Checking
	// ********************************
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs

	task tally(input bit ok, input logic [33:0] g, input logic [33:0] e);
		n_tests++;
		if (!ok) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : tally

	task cmp_rd(input logic [33:0] g, input logic [33:0] e);
		tally(g === e, g, e);
	endtask : cmp_rd

	task cmp_b(input logic [1:0] g, input logic [1:0] e);
		tally(g === e, {32'h0, g}, {32'h0, e});
	endtask : cmp_b

	task cmp_pin(input int g, input int e, input int tol);
		tally((g >= e - tol) && (g <= e + tol), 34'(g), 34'(e));
	endtask : cmp_pin

	always @(posedge aclk) begin
		if (bvalid === 1'b1 && bready) cmp_b(bresp, b_q.pop_front());
		if (rvalid === 1'b1 && rready) cmp_rd({rresp, rdata}, r_q.pop_front());
	end

	task w(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
		b_q.push_back(e);
		u_host.wr(a, d, s);
	endtask : w

	task r(input logic [7:0] a, input logic [33:0] e);
		r_q.push_back(e);
		u_host.rd(a);
	endtask : r

	task meas(input int skip, input int n, output int hi);
		repeat (skip) @(posedge aclk);
		hi = 0;
		repeat (n) begin
			@(posedge aclk);
			hi += (interval_out === 1'b1);
		end
	endtask : meas

	task end_sim;
		if (bad_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			end_sim;
		end
	end

	// ********************************
	// Scenarios
	// ********************************
	initial begin
		aresetn = 1'b0;
		output_gate_pin = 1'b0;
		seed = 32'h12C91404;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (120) @(posedge aclk);
		output_gate_pin <= 1'b1;
		meas(10, 300, h); cmp_pin(h, 0, 0);
		output_gate_pin <= 1'b0;
		meas(10, 50, h); cmp_pin(h, 50, 0);
		r(8'h00, 34'h0);
		r(8'h04, 34'h0);
		w(8'h0C, 32'h3, 4'hF, 2'h0);
		r(8'h0C, 34'h3);
		r(8'h08, 34'h0);
		cmp_b({1'b0, irq}, 2'h0);
		w(8'h04, 32'hFF, 4'hF, 2'h0);
		r(8'h04, 34'h0);
		w(8'h10, 32'h1, 4'hF, 2'h3);
		r(8'h10, {2'h3, 32'h0});
		w(8'h00, 32'h0000FFC2, 4'h3, 2'h0);
		r(8'h00, 34'hFFC0);
		w(8'h00, 32'h00000047, 4'hC, 2'h0);
		r(8'h00, 34'hFFC0);
		r(8'h04, 34'h0);
		output_gate_pin <= 1'b1;
		repeat (10) @(posedge aclk);
		// The four fastest taps, so one window of 2048 cycles holds whole periods of each.
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			sel = seed[3:0];
			if (i % 2 == 1) begin
				output_gate_pin <= 1'b0;
				repeat (10) @(posedge aclk);
			end
			w(8'h00, {16'h0, sel, 12'h007}, 4'h3, 2'h0);
			if (i % 2 == 1) begin
				meas(4, 20, h); cmp_pin(h, 20, 0);
				output_gate_pin <= 1'b1;
			end
			r(8'h00, {18'h0, sel, 12'h0});
			meas(12, 2048, h);
			cmp_pin(h, (sel == 0) ? 0 : (2048 >> $countones(sel)), (sel == 0) ? 0 : 12);
		end
		// The slowest tap restarts low and stays low long after the write.
		w(8'h00, 32'h00000047, 4'h3, 2'h0);
		meas(8, 100, h); cmp_pin(h, 0, 0);
		// The write above restarted the second, so no tick may come before its full length.
		repeat (15800) @(posedge aclk);
		r(8'h04, 34'h0);
		repeat (600) @(posedge aclk);
		r(8'h04, 34'h1);
		r(8'h08, 34'h1);
		cmp_b({1'b0, irq}, 2'h1);
		w(8'h08, 32'h1, 4'hF, 2'h0);
		cmp_b({1'b0, irq}, 2'h0);
		w(8'h00, 32'h00000042, 4'h3, 2'h0);
		r(8'h04, 34'h0);
		r(8'h00, 34'h40);
		repeat (16600) @(posedge aclk);
		r(8'h04, 34'h1);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		w(8'h00, 32'h0000C007, 4'h3, 2'h0);
		meas(0, 40, h); cmp_pin(h, 0, 0);
		meas(100, 2048, h); cmp_pin(h, 512, 12);
		r(8'h00, 34'hC000);
		end_sim;
	end
endmodule : test_interval_signal_and_seconds_timer
